// ---- fb_level.sv ----
// Frame buffer empty flag from write and read counts
`default_nettype none
module fb_level (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire indicator_pkg::fb_cnt_t cnt,
  output logic                        empty_q
);
  logic empty_d;

  // Appended status bytes lie beyond len and never count as empty
  always_comb begin
    empty_d = (cnt.rd_cnt >= cnt.wr_cnt) && (cnt.rd_cnt < cnt.len);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_q <= 1'b1;
    end else begin
      empty_q <= empty_d;
    end
  end
endmodule : fb_level
`default_nettype wire

// ---- fb_reader_model.sv ----
// Host model that reads the frame buffer while watching the event pin
`default_nettype none
module fb_reader_model #(
  parameter int unsigned OCTET_CYC = 150
) (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       evt_pin,
  input  wire logic [7:0] len,
  output logic            sel_n,
  output logic            cmd_done,
  output logic [7:0]      rd_cnt,
  output logic            aborted
);
  int stall;

  // ---------------------------------------------------------------
  // Read procedure
  // ---------------------------------------------------------------
  initial begin
    sel_n = 1'b1;
    cmd_done = 1'b0;
    rd_cnt = 8'h00;
    aborted = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        #1;
        rd_cnt = 8'h00;
        aborted = 1'b0;
        sel_n = 1'b0;
        cmd_done = 1'b1;
        @(posedge clk);
        #1;
        cmd_done = 1'b0;
        repeat (80) @(posedge clk);
        stall = 0;
        while (sel_n == 1'b0) begin
          repeat (4) @(posedge clk);
          #1;
          if (evt_pin == 1'b0) begin
            rd_cnt = rd_cnt + 8'h01;
            stall = 0;
          end else begin
            stall = stall + 4;
          end
          if (rd_cnt == len + 8'h03) begin
            sel_n = 1'b1;
          end else if (stall > 2 * OCTET_CYC) begin
            sel_n = 1'b1;
            aborted = 1'b1;
          end
        end
      end
    end
  end
endmodule : fb_reader_model
`default_nettype wire

// ---- indicator_pkg.sv ----
// Constants, register map and shared types of the radio status indicator
`default_nettype none
package indicator_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 6;
  localparam int unsigned DATA_W        = 8;
  localparam logic [5:0]  TRX_CTRL_OFS  = 6'h04;
  localparam logic [5:0]  EXT_CTRL_OFS  = 6'h17;
  localparam logic [7:0]  TRX_CTRL_RST  = 8'h22;
  localparam logic [7:0]  EXT_CTRL_RST  = 8'h00;
  localparam logic [7:0]  EXT_CTRL_WMSK = 8'hF7;
  localparam logic [7:0]  UNMAPPED_RD   = 8'h00;

  // Field positions
  localparam int unsigned FE_EN_BIT     = 7;
  localparam int unsigned RXS_PIN_BIT   = 6;
  localparam int unsigned BL_EN_BIT     = 4;
  localparam int unsigned STAMP_EN_BIT  = 7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FE_ON_NS      = 6000;
  localparam int unsigned FE_OFF_NS     = 3000;
  localparam int unsigned IND_VALID_NS  = 750;
  localparam int unsigned CNT_W         = 10;
  localparam int unsigned FE_ON_CYC     =
    (FE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FE_OFF_CYC    =
    (FE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IND_VALID_CYC =
    (IND_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FB_CNT_W      = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FE_RX     = 4'h1,
    FE_ARM    = 4'h2,
    FE_TX     = 4'h4,
    FE_DISARM = 4'h8
  } fe_state_t;

  typedef enum logic [3:0] {
    IND_OFF    = 4'h1,
    IND_WAIT   = 4'h2,
    IND_ACTIVE = 4'h4,
    IND_LOCK   = 4'h8
  } ind_state_t;

  typedef struct packed {
    logic tx_req;
    logic pa_off;
    logic phr_valid;
    logic tx_start;
    logic frame_end;
    logic rx_error;
  } radio_evt_t;

  typedef struct packed {
    logic [7:0] wr_cnt;
    logic [7:0] rd_cnt;
    logic [7:0] len;
  } fb_cnt_t;

endpackage : indicator_pkg
`default_nettype wire

// ---- pulse_delay.sv ----
// Retriggerable delay: done pulses CYCLES edges after start
`default_nettype none
module pulse_delay #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic cancel,
  output logic      done
);
  logic [indicator_pkg::CNT_W-1:0] cnt_q;
  logic [indicator_pkg::CNT_W-1:0] cnt_d;
  logic                            busy_q;
  logic                            busy_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (start) begin
      cnt_d  = indicator_pkg::CNT_W'(CYCLES - 1);
      busy_d = 1'b1;
    end else if (cancel || done) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  assign done = busy_q && (cnt_q == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end
endmodule : pulse_delay
`default_nettype wire

// ---- radio_status_indicator_pins.sv ----
// Status pin logic: front-end pair, time-stamp pin, buffer-empty pin
`default_nettype none
module radio_status_indicator_pins (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      REG_WR,
  input  wire logic [5:0]                REG_ADDR,
  input  wire logic [7:0]                REG_WDATA,
  output logic      [7:0]                REG_RDATA,
  input  wire indicator_pkg::radio_evt_t RADIO_EVT,
  input  wire logic                      ARET_STATE,
  input  wire logic                      ANT_SW_EN,
  input  wire logic                      ANT_SW_LEVEL,
  input  wire logic                      FB_READ_CMD_DONE,
  input  wire logic                      SEL_N,
  input  wire indicator_pkg::fb_cnt_t    FB_CNT,
  input  wire logic                      IRQ_IN,
  output logic                           FE_CTRL_A,
  output logic                           FE_CTRL_B,
  output logic                           TIME_STAMP_PIN,
  output logic                           HOST_EVENT_PIN
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] trx_ctrl_one_q;
  logic [7:0] trx_ctrl_one_d;
  logic [7:0] ext_ctrl_one_q;
  logic [7:0] ext_ctrl_one_d;
  logic [7:0] rdata_d;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    trx_ctrl_one_d = trx_ctrl_one_q;
    ext_ctrl_one_d = ext_ctrl_one_q;
    if (REG_WR && hit(REG_ADDR, indicator_pkg::TRX_CTRL_OFS)) begin
      trx_ctrl_one_d = REG_WDATA;
    end
    // Reserved bit 3 is read-only zero
    if (REG_WR && hit(REG_ADDR, indicator_pkg::EXT_CTRL_OFS)) begin
      ext_ctrl_one_d = REG_WDATA & indicator_pkg::EXT_CTRL_WMSK;
    end
    if (hit(REG_ADDR, indicator_pkg::TRX_CTRL_OFS)) begin
      rdata_d = trx_ctrl_one_q;
    end else if (hit(REG_ADDR, indicator_pkg::EXT_CTRL_OFS)) begin
      rdata_d = ext_ctrl_one_q;
    end else begin
      rdata_d = indicator_pkg::UNMAPPED_RD;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trx_ctrl_one_q <= indicator_pkg::TRX_CTRL_RST;
      ext_ctrl_one_q <= indicator_pkg::EXT_CTRL_RST;
      REG_RDATA      <= indicator_pkg::UNMAPPED_RD;
    end else begin
      trx_ctrl_one_q <= trx_ctrl_one_d;
      ext_ctrl_one_q <= ext_ctrl_one_d;
      REG_RDATA      <= rdata_d;
    end
  end

  logic front_end_indicate_en;
  logic rx_start_pin_en;
  logic buffer_empty_ind_en;
  logic retry_tx_stamp_en;

  assign front_end_indicate_en = trx_ctrl_one_q[indicator_pkg::FE_EN_BIT];
  assign rx_start_pin_en       = trx_ctrl_one_q[indicator_pkg::RXS_PIN_BIT];
  assign buffer_empty_ind_en   = trx_ctrl_one_q[indicator_pkg::BL_EN_BIT];
  assign retry_tx_stamp_en     = ext_ctrl_one_q[indicator_pkg::STAMP_EN_BIT];

  // ---------------------------------------------------------------
  // Front-end control pair
  // ---------------------------------------------------------------
  indicator_pkg::fe_state_t fe_q;
  indicator_pkg::fe_state_t fe_d;
  logic                     fe_on_start;
  logic                     fe_off_start;
  logic                     fe_on_done;
  logic                     fe_off_done;
  logic                     tx_ind;
  logic                     fe_a_d;
  logic                     fe_b_d;

  pulse_delay #(
    .CYCLES (indicator_pkg::FE_ON_CYC)
  ) u_fe_on (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .start  (fe_on_start),
    .cancel (1'b0),
    .done   (fe_on_done)
  );

  pulse_delay #(
    .CYCLES (indicator_pkg::FE_OFF_CYC)
  ) u_fe_off (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .start  (fe_off_start),
    .cancel (1'b0),
    .done   (fe_off_done)
  );

  always_comb begin
    fe_d         = fe_q;
    fe_on_start  = 1'b0;
    fe_off_start = 1'b0;
    case (fe_q)
      indicator_pkg::FE_RX: begin
        if (RADIO_EVT.tx_req) begin
          fe_d        = indicator_pkg::FE_ARM;
          fe_on_start = 1'b1;
        end
      end
      indicator_pkg::FE_ARM: begin
        if (fe_on_done) begin
          fe_d = indicator_pkg::FE_TX;
        end
      end
      indicator_pkg::FE_TX: begin
        if (RADIO_EVT.pa_off) begin
          fe_d         = indicator_pkg::FE_DISARM;
          fe_off_start = 1'b1;
        end
      end
      indicator_pkg::FE_DISARM: begin
        if (fe_off_done) begin
          fe_d = indicator_pkg::FE_RX;
        end
      end
      default: fe_d = indicator_pkg::FE_RX;
    endcase
    tx_ind = (fe_d == indicator_pkg::FE_TX) ||
             (fe_d == indicator_pkg::FE_DISARM);
    fe_a_d = front_end_indicate_en && tx_ind;
    fe_b_d = front_end_indicate_en && !tx_ind;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fe_q      <= indicator_pkg::FE_RX;
      FE_CTRL_A <= 1'b0;
      FE_CTRL_B <= 1'b0;
    end else begin
      fe_q      <= fe_d;
      FE_CTRL_A <= fe_a_d;
      FE_CTRL_B <= fe_b_d;
    end
  end

  // ---------------------------------------------------------------
  // Time-stamp pin
  // ---------------------------------------------------------------
  logic stamp_q;
  logic stamp_d;
  logic stamp_set;
  logic ts_pin_d;

  // Interrupt mask plays no part, so stamps show even when masked
  always_comb begin
    stamp_set = rx_start_pin_en &&
                (RADIO_EVT.phr_valid ||
                 (RADIO_EVT.tx_start && ARET_STATE &&
                  retry_tx_stamp_en));
    if (stamp_set) begin
      stamp_d = 1'b1;
    end else if (RADIO_EVT.frame_end || !rx_start_pin_en) begin
      stamp_d = 1'b0;
    end else begin
      stamp_d = stamp_q;
    end
    if (rx_start_pin_en) begin
      ts_pin_d = stamp_d;
    end else if (ANT_SW_EN) begin
      ts_pin_d = ANT_SW_LEVEL;
    end else begin
      ts_pin_d = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stamp_q        <= 1'b0;
      TIME_STAMP_PIN <= 1'b0;
    end else begin
      stamp_q        <= stamp_d;
      TIME_STAMP_PIN <= ts_pin_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame buffer empty indicator on host event pin
  // ---------------------------------------------------------------
  indicator_pkg::ind_state_t ind_q;
  indicator_pkg::ind_state_t ind_d;
  logic                      ind_start;
  logic                      ind_done;
  logic                      fb_empty;
  logic                      host_pin_d;

  pulse_delay #(
    .CYCLES (indicator_pkg::IND_VALID_CYC)
  ) u_ind_valid (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .start  (ind_start),
    .cancel (SEL_N),
    .done   (ind_done)
  );

  fb_level u_fb_level (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .cnt     (FB_CNT),
    .empty_q (fb_empty)
  );

  always_comb begin
    ind_d     = ind_q;
    ind_start = 1'b0;
    case (ind_q)
      indicator_pkg::IND_OFF: begin
        if (buffer_empty_ind_en && FB_READ_CMD_DONE && !SEL_N) begin
          ind_d     = indicator_pkg::IND_WAIT;
          ind_start = 1'b1;
        end
      end
      indicator_pkg::IND_WAIT: begin
        if (SEL_N) begin
          ind_d = indicator_pkg::IND_OFF;
        end else if (RADIO_EVT.rx_error) begin
          ind_d = indicator_pkg::IND_LOCK;
        end else if (ind_done) begin
          ind_d = indicator_pkg::IND_ACTIVE;
        end
      end
      indicator_pkg::IND_ACTIVE: begin
        if (SEL_N) begin
          ind_d = indicator_pkg::IND_OFF;
        end else if (RADIO_EVT.rx_error) begin
          ind_d = indicator_pkg::IND_LOCK;
        end
      end
      indicator_pkg::IND_LOCK: begin
        if (SEL_N) begin
          ind_d = indicator_pkg::IND_OFF;
        end
      end
      default: ind_d = indicator_pkg::IND_OFF;
    endcase
    case (ind_d)
      indicator_pkg::IND_OFF:    host_pin_d = IRQ_IN;
      indicator_pkg::IND_ACTIVE: host_pin_d = fb_empty;
      default:                   host_pin_d = 1'b1;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ind_q          <= indicator_pkg::IND_OFF;
      HOST_EVENT_PIN <= 1'b0;
    end else begin
      ind_q          <= ind_d;
      HOST_EVENT_PIN <= host_pin_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int FE_ON_LO  = 599;
  localparam int FE_ON_HI  = 602;
  localparam int IND_LO    = 74;
  localparam int IND_HI    = 77;

  logic tx_ind_q_chk;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  fe_pins_off_a: assert property (
    !front_end_indicate_en |=> !FE_CTRL_A && !FE_CTRL_B)
    else $error("front-end pins not low while disabled");

  fe_pins_diff_a: assert property (
    front_end_indicate_en |=> FE_CTRL_A == tx_ind_q_chk &&
      FE_CTRL_B == !tx_ind_q_chk)
    else $error("front-end pin A does not follow transmit state");

  fe_on_delay_a: assert property (
    (fe_q == indicator_pkg::FE_RX) && RADIO_EVT.tx_req |->
      ##[FE_ON_LO:FE_ON_HI] (fe_q == indicator_pkg::FE_TX))
    else $error("transmit indication not shown 6us after request");

  stamp_rise_a: assert property (
    rx_start_pin_en && RADIO_EVT.phr_valid |=> TIME_STAMP_PIN)
    else $error("time-stamp pin did not rise on valid header");

  stamp_hold_a: assert property (
    stamp_q && rx_start_pin_en && !RADIO_EVT.frame_end |=> stamp_q)
    else $error("time-stamp dropped before frame end");

  stamp_tx_retry_a: assert property (
    !stamp_q && RADIO_EVT.tx_start && !ARET_STATE &&
    !RADIO_EVT.phr_valid |=> !stamp_q)
    else $error("transmit stamp outside retry state");

  stamp_ground_a: assert property (
    !rx_start_pin_en && !ANT_SW_EN |=> !TIME_STAMP_PIN)
    else $error("unused time-stamp pin not grounded");

  ind_valid_a: assert property (
    (ind_q == indicator_pkg::IND_OFF) && buffer_empty_ind_en &&
    FB_READ_CMD_DONE && !SEL_N ##1 (!SEL_N && !RADIO_EVT.rx_error)[*8]
    |-> ##[IND_LO:IND_HI] (ind_q != indicator_pkg::IND_WAIT))
    else $error("empty indicator not valid after 750ns");

  ind_no_irq_a: assert property (
    (ind_q == indicator_pkg::IND_WAIT) |-> HOST_EVENT_PIN)
    else $error("interrupt shown while indicator not yet valid");

  ind_lock_a: assert property (
    (ind_q == indicator_pkg::IND_LOCK) && !SEL_N |=> HOST_EVENT_PIN)
    else $error("indicator left empty after receive error");

  irq_restore_a: assert property (
    SEL_N |=> (HOST_EVENT_PIN == $past(IRQ_IN)))
    else $error("host event pin not back to interrupts");

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_ind_q_chk <= 1'b0;
    end else begin
      tx_ind_q_chk <= tx_ind;
    end
  end

  fe_tx_c: cover property (
    front_end_indicate_en && (fe_q == indicator_pkg::FE_DISARM) ##1
    (fe_q == indicator_pkg::FE_RX));
  stamp_frame_c: cover property ($rose(TIME_STAMP_PIN) ##[1:50]
    $fell(TIME_STAMP_PIN));
  ind_read_c: cover property ((ind_q == indicator_pkg::IND_ACTIVE) ##1
    (ind_q == indicator_pkg::IND_OFF));
  ind_lock_c: cover property (ind_q == indicator_pkg::IND_LOCK);

endmodule : radio_status_indicator_pins
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the radio status indicator pins
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TXR = 5, PAO = 4, PHR = 3, TXS = 2, FEND = 1, RXE = 0;
  logic                      clk, rst_n, reg_wr, start, lock, mon_on;
  logic [5:0]                reg_addr;
  logic [7:0]                reg_wdata, reg_rdata, wr_cnt, rd_cnt, len, d;
  indicator_pkg::radio_evt_t evt;
  indicator_pkg::fb_cnt_t    fb_cnt, fb_prev;
  logic                      aret, ant_en, ant_lvl, irq, hit, idle;
  logic                      fe_a, fe_b, ts_pin, hep, sel_n, cmd_done, aborted;
  int                        miscompares, num_checks, stable;

  assign fb_cnt = {wr_cnt, rd_cnt, len};

  radio_status_indicator_pins u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .RADIO_EVT(evt),
    .ARET_STATE(aret), .ANT_SW_EN(ant_en), .ANT_SW_LEVEL(ant_lvl),
    .FB_READ_CMD_DONE(cmd_done), .SEL_N(sel_n), .FB_CNT(fb_cnt),
    .IRQ_IN(irq), .FE_CTRL_A(fe_a), .FE_CTRL_B(fe_b),
    .TIME_STAMP_PIN(ts_pin), .HOST_EVENT_PIN(hep)
  );

  fb_reader_model #(.OCTET_CYC(150)) u_host (
    .clk(clk), .start(start), .evt_pin(hep), .len(len), .sel_n(sel_n),
    .cmd_done(cmd_done), .rd_cnt(rd_cnt), .aborted(aborted)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic got, input logic exp, input string nm);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s pin got %b exp %b", $time, nm, got, exp);
    end
  endtask : cmp_pin

  task automatic chk_fe(input logic a, input logic b);
    cmp_pin(fe_a, a, "fe_a");
    cmp_pin(fe_b, b, "fe_b");
  endtask : chk_fe

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] dt);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = dt;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(2);
    cmp_reg(reg_rdata, exp);
  endtask : rd_chk

  task automatic pulse(input int b);
    evt = indicator_pkg::radio_evt_t'(6'h01 << b);
    tick(1);
    evt = '0;
  endtask : pulse

  task automatic go_read();
    lock = 1'b0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask : go_read

  task automatic wait_sel();
    int k;
    k = 0;
    while (sel_n !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    if (sel_n !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t buffer read never ended", $time);
    end
    mon_on = 1'b0;
  endtask : wait_sel

  function automatic logic exp_empty(input logic lk, input logic [7:0] rd,
                                     input logic [7:0] wr, input logic [7:0] ln);
    return lk | ((rd >= wr) & (rd < ln));
  endfunction : exp_empty

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // Indicator level once the counts have settled for three cycles
  always @(negedge clk) begin
    stable = (fb_cnt === fb_prev) ? stable + 1 : 0;
    fb_prev = fb_cnt;
    if (mon_on && sel_n === 1'b0 && stable >= 3) begin
      cmp_pin(hep, exp_empty(lock, rd_cnt, wr_cnt, len), "empty");
    end
  end

  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_addr = 6'h00; reg_wdata = 8'h00;
    evt = '0; aret = 1'b0; ant_en = 1'b0; ant_lvl = 1'b0; irq = 1'b0;
    start = 1'b0; lock = 1'b0; mon_on = 1'b0; wr_cnt = 8'h00; len = 8'h00;
    miscompares = 0; num_checks = 0; stable = 0; fb_prev = '0;
    void'($urandom(32'h11A4));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    irq = 1'($urandom);
    tick(2);
    cmp_pin(hep, irq, "irq");
    rd_chk(indicator_pkg::TRX_CTRL_OFS, indicator_pkg::TRX_CTRL_RST);
    rd_chk(indicator_pkg::EXT_CTRL_OFS, indicator_pkg::EXT_CTRL_RST);
    reg_addr = 6'($urandom_range(24, 63));
    wr_reg(reg_addr, 8'($urandom));
    rd_chk(reg_addr, indicator_pkg::UNMAPPED_RD);
    rd_chk(indicator_pkg::TRX_CTRL_OFS, indicator_pkg::TRX_CTRL_RST);
    d = 8'($urandom);
    wr_reg(6'h17, d);
    rd_chk(6'h17, d & indicator_pkg::EXT_CTRL_WMSK);
    // Front-end pair
    chk_fe(1'b0, 1'b0);
    wr_reg(6'h04, 8'h80);
    tick(1);
    chk_fe(1'b0, 1'b1);
    pulse(TXR);
    tick(590);
    chk_fe(1'b0, 1'b1);
    tick(20);
    chk_fe(1'b1, 1'b0);
    pulse(TXR);
    wr_reg(6'h04, 8'h00);
    tick(1);
    chk_fe(1'b0, 1'b0);
    wr_reg(6'h04, 8'h80);
    tick(1);
    chk_fe(1'b1, 1'b0);
    pulse(PAO);
    tick(290);
    chk_fe(1'b1, 1'b0);
    tick(20);
    chk_fe(1'b0, 1'b1);
    // Time stamping over every gate combination
    for (int i = 0; i < 16; i++) begin
      ant_en = 1'($urandom);
      ant_lvl = 1'($urandom);
      irq = 1'($urandom);
      aret = i[2];
      wr_reg(6'h04, {1'b0, i[0], 6'h00});
      wr_reg(6'h17, {i[1], 7'h00});
      idle = i[0] ? 1'b0 : (ant_en & ant_lvl);
      hit = i[0] & (~i[3] | (i[1] & i[2]));
      cmp_pin(ts_pin, idle, "idle");
      pulse(i[3] ? TXS : PHR);
      cmp_pin(ts_pin, hit | idle, "start");
      tick($urandom_range(1, 40));
      cmp_pin(ts_pin, hit | idle, "hold");
      pulse(FEND);
      cmp_pin(ts_pin, idle, "end");
      tick(1);
    end
    // Buffer read with data trickling in
    aret = 1'b0;
    wr_reg(6'h04, 8'h10);
    len = 8'($urandom_range(10, 30));
    wr_cnt = 8'h02;
    irq = 1'b0;
    go_read();
    tick(3);
    cmp_pin(hep, 1'b1, "cmd");
    tick(60);
    cmp_pin(hep, 1'b1, "wait");
    irq = 1'b1;
    tick(25);
    mon_on = 1'b1;
    while (sel_n === 1'b0 && wr_cnt < len) begin
      tick($urandom_range(5, 40));
      wr_cnt = wr_cnt + 8'h01;
    end
    wait_sel();
    cmp_pin(aborted, 1'b0, "abort");
    tick(2);
    cmp_pin(hep, irq, "irq");
    irq = 1'b0;
    tick(2);
    cmp_pin(hep, irq, "irq");
    // Receive error in mid-read
    wr_cnt = 8'h03;
    go_read();
    tick(90);
    mon_on = 1'b1;
    tick(40);
    pulse(RXE);
    tick(2);
    lock = 1'b1;
    wr_cnt = len;
    wait_sel();
    cmp_pin(aborted, 1'b1, "abort");
    tick(2);
    cmp_pin(hep, irq, "irq");
    // Indicator disabled
    wr_reg(6'h04, 8'h00);
    go_read();
    tick(90);
    cmp_pin(hep, irq, "off");
    irq = 1'b1;
    tick(2);
    cmp_pin(hep, irq, "off");
    wait_sel();
    tick(2);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
